// ### rtl/pesd_regs.svh
// Event numbers, unit masks and sizes for the event-selection decoder.
// Assumes inclusion by rtl files only; definitions only.
`ifndef PESD_REGS_SVH
`define PESD_REGS_SVH

// ****************************************************************
// Core event numbers
// ****************************************************************
`define PESD_EV_SQ_FULL      8'hF6
`define PESD_EV_FLOAT_ASSIST 8'hF7
`define PESD_EV_VEC64        8'hFD

// ****************************************************************
// Uncore event numbers
// ****************************************************************
`define PESD_EV_GQ_FULL      8'h00
`define PESD_EV_GQ_OCCUPIED  8'h01

// ****************************************************************
// Unit mask bits and legal masks per event
// ****************************************************************
`define PESD_UM_SQ_FULL      8'h01
`define PESD_UM_ASSIST_ANY   8'h01
`define PESD_UM_ASSIST_RES   8'h02
`define PESD_UM_ASSIST_OPND  8'h04
`define PESD_UM_VEC64_ALL    8'h7F
`define PESD_UM_GQ_READ      8'h01
`define PESD_UM_GQ_WRITE     8'h02
`define PESD_UM_GQ_PROBE     8'h04
`define PESD_LEGAL_SQ        8'h01
`define PESD_LEGAL_ASSIST    8'h07
`define PESD_LEGAL_VEC64     8'h7F
`define PESD_LEGAL_GQ_FULL   8'h07
`define PESD_LEGAL_GQ_OCC    8'h01

// ****************************************************************
// Sizes and reset values
// ****************************************************************
`define PESD_CNT_W           48
`define PESD_PROBE_DEPTH     16
`define PESD_CNT_RESET       48'h0000_0000_0000

`endif

// ### rtl/pesd_pkg.sv
// Types shared by the event-selection decoder files.
// Assumes nothing beyond a SystemVerilog compiler.
package pesd_pkg;

    // ****************************************************************
    // Selection
    // ****************************************************************
    typedef struct packed {
        logic       uncore;
        logic [7:0] event_num;
        logic [7:0] unit_mask;
    } pesd_sel_t;

    // ****************************************************************
    // Core status strobes
    // ****************************************************************
    typedef struct packed {
        logic       super_queue_full;
        logic       sse_op;
        logic       sse_denormal_in;
        logic       sse_underflow;
        logic       denormals_as_zero_flag;
        logic       flush_to_zero_flag;
        logic       x87_op;
        logic       x87_nan_denormal_load;
        logic       x87_div_zero;
        logic       x87_underflow;
        logic [6:0] vec64_ops;
    } pesd_core_ev_t;

    // ****************************************************************
    // Uncore status strobes
    // ****************************************************************
    typedef struct packed {
        logic read_tracker_full;
        logic write_tracker_full;
        logic read_tracker_occupied;
        logic probe_alloc_io_hub;
        logic probe_alloc_remote;
        logic probe_dealloc;
    } pesd_unc_ev_t;

endpackage

// ### rtl/pesd_probe_tracker.sv
// Peer-probe tracker occupancy: snoops from the io hub and remote sockets.
// Assumes strobes from logic on clk_i; one dealloc per cycle at most.
`timescale 1ns/1ps
`include "pesd_regs.svh"

module pesd_probe_tracker #(
    parameter int DEPTH = `PESD_PROBE_DEPTH
) (
    // Clock and reset
    input  wire logic clk_i,
    input  wire logic reset_n_i,
    // Snoop strobes
    input  wire logic alloc_io_hub_i,
    input  wire logic alloc_remote_i,
    input  wire logic dealloc_i,
    // Status
    output logic      full_o,
    output logic      not_empty_o
);

    localparam int OCC_W = $clog2(DEPTH + 1);
    localparam logic [OCC_W-1:0] DEPTH_V = OCC_W'(DEPTH);

    typedef struct packed {
        logic [OCC_W-1:0] occ;
        logic             full;
        logic             not_empty;
    } pesd_trk_state_t;

    pesd_trk_state_t state_q;
    pesd_trk_state_t state_d;

    // ****************************************************************
    // Occupancy
    // ****************************************************************
    always_comb begin
        logic [OCC_W:0] next;
        next = {1'b0, state_q.occ};
        if (dealloc_i && state_q.occ != '0) begin
            next = next - 1'b1;
        end
        // Snoops from both sources land here
        if (alloc_io_hub_i && next < {1'b0, DEPTH_V}) begin
            next = next + 1'b1;
        end
        if (alloc_remote_i && next < {1'b0, DEPTH_V}) begin
            next = next + 1'b1;
        end
        state_d.occ       = next[OCC_W-1:0];
        state_d.full      = (next[OCC_W-1:0] == DEPTH_V);
        state_d.not_empty = (next[OCC_W-1:0] != '0);
    end

    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            state_q <= '0;
        end else begin
            state_q <= state_d;
        end
    end

    assign full_o      = state_q.full;
    assign not_empty_o = state_q.not_empty;

    // ****************************************************************
    // Checks
    // ****************************************************************
    probe_fill_a : assert property (@(posedge clk_i) disable iff (!reset_n_i)
        (!not_empty_o && alloc_io_hub_i && !dealloc_i) |=> not_empty_o)
        else $error("probe tracker missed io hub snoop");
    probe_full_cv : cover property (@(posedge clk_i) disable iff (!reset_n_i) full_o);

endmodule

// ### rtl/pesd_top.sv
// Event-selection decoder and counter for core and uncore events.
// Assumes all strobes come from logic on clk_i; selection held by software.
// Overview of operation
// - Super queue full, each cycle counts
// - Full super queue blocks both threads' uncore issue
// - Count floating operations needing microcode assist
// - SSE assist: denormal or underflow, flag clear
// - x87 assist: NaN/denormal load, divide zero, underflow
// - Count assists caused by invalid result
// - Count assists caused by invalid source operand
// - Mask bits choose 64-bit vector op classes
// - Count cycles chosen global-queue tracker is full
// - Peer-probe tracker holds io hub, remote snoops
// - Count cycles read tracker holds entries
`timescale 1ns/1ps
`include "pesd_regs.svh"

module pesd_top #(
    parameter int CNT_W       = `PESD_CNT_W,
    parameter int PROBE_DEPTH = `PESD_PROBE_DEPTH
) (
    // Clock and reset
    input  wire logic                    clk_i,
    input  wire logic                    reset_n_i,
    // Selection
    input  wire pesd_pkg::pesd_sel_t     sel_i,
    // Event strobes
    input  wire pesd_pkg::pesd_core_ev_t core_ev_i,
    input  wire pesd_pkg::pesd_unc_ev_t  unc_ev_i,
    // Results
    output logic [CNT_W-1:0]             count_o,
    output logic [1:0]                   uncore_issue_block_o
);

    typedef struct packed {
        logic [CNT_W-1:0] count;
        logic [1:0]       issue_block;
    } pesd_state_t;

    pesd_state_t state_q;
    pesd_state_t state_d;

    logic       probe_full;
    logic       probe_not_empty;
    logic       sse_assist;
    logic       x87_assist;
    logic       bad_result;
    logic       bad_operand;
    logic [7:0] cond;
    logic [7:0] legal;
    logic       known;
    logic       match;
    logic [3:0] inc;

    // ****************************************************************
    // Helpers
    // ****************************************************************
    function automatic logic sel_is(input pesd_pkg::pesd_sel_t s,
                                    input logic unc,
                                    input logic [7:0] ev);
        sel_is = (s.uncore == unc) && (s.event_num == ev);
    endfunction

    function automatic logic [3:0] ones(input logic [7:0] v);
        logic [3:0] n;
        n = 4'h0;
        for (int i = 0; i < 8; i++) begin
            n = n + {3'h0, v[i]};
        end
        ones = n;
    endfunction

    // ****************************************************************
    // Peer-probe tracker
    // ****************************************************************
    pesd_probe_tracker #(
        .DEPTH (PROBE_DEPTH)
    ) u_probe (
        .clk_i          (clk_i),
        .reset_n_i      (reset_n_i),
        .alloc_io_hub_i (unc_ev_i.probe_alloc_io_hub),
        .alloc_remote_i (unc_ev_i.probe_alloc_remote),
        .dealloc_i      (unc_ev_i.probe_dealloc),
        .full_o         (probe_full),
        .not_empty_o    (probe_not_empty)
    );

    // ****************************************************************
    // Assist causes
    // ****************************************************************
    always_comb begin
        sse_assist  = core_ev_i.sse_op &&
                      ((core_ev_i.sse_denormal_in && !core_ev_i.denormals_as_zero_flag) ||
                       (core_ev_i.sse_underflow && !core_ev_i.flush_to_zero_flag));
        x87_assist  = core_ev_i.x87_op &&
                      (core_ev_i.x87_nan_denormal_load || core_ev_i.x87_div_zero ||
                       core_ev_i.x87_underflow);
        bad_result  = (core_ev_i.sse_op && core_ev_i.sse_underflow &&
                       !core_ev_i.flush_to_zero_flag) ||
                      (core_ev_i.x87_op && core_ev_i.x87_underflow);
        bad_operand = (core_ev_i.sse_op && core_ev_i.sse_denormal_in &&
                       !core_ev_i.denormals_as_zero_flag) ||
                      (core_ev_i.x87_op &&
                       (core_ev_i.x87_nan_denormal_load || core_ev_i.x87_div_zero));
    end

    // ****************************************************************
    // Event decode
    // ****************************************************************
    always_comb begin
        cond  = 8'h00;
        legal = 8'h00;
        known = 1'b1;
        if (sel_is(sel_i, 1'b0, `PESD_EV_SQ_FULL)) begin
            cond  = {7'h00, core_ev_i.super_queue_full};
            legal = `PESD_LEGAL_SQ;
        end else if (sel_is(sel_i, 1'b0, `PESD_EV_FLOAT_ASSIST)) begin
            cond  = {5'h00, bad_operand, bad_result, sse_assist || x87_assist};
            legal = `PESD_LEGAL_ASSIST;
        end else if (sel_is(sel_i, 1'b0, `PESD_EV_VEC64)) begin
            cond  = {1'b0, core_ev_i.vec64_ops};
            legal = `PESD_LEGAL_VEC64;
        end else if (sel_is(sel_i, 1'b1, `PESD_EV_GQ_FULL)) begin
            cond  = {5'h00, probe_full, unc_ev_i.write_tracker_full,
                     unc_ev_i.read_tracker_full};
            legal = `PESD_LEGAL_GQ_FULL;
        end else if (sel_is(sel_i, 1'b1, `PESD_EV_GQ_OCCUPIED)) begin
            cond  = {7'h00, unc_ev_i.read_tracker_occupied};
            legal = `PESD_LEGAL_GQ_OCC;
        end else begin
            known = 1'b0;
        end
        match = known && (sel_i.unit_mask != 8'h00) &&
                ((sel_i.unit_mask & ~legal) == 8'h00);
        inc   = match ? ones(cond & sel_i.unit_mask) : 4'h0;
    end

    // ****************************************************************
    // State update
    // ****************************************************************
    always_comb begin
        state_d             = state_q;
        state_d.count       = state_q.count + CNT_W'(inc);
        state_d.issue_block = {2{core_ev_i.super_queue_full}};
    end

    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            state_q <= '0;
        end else begin
            state_q <= state_d;
        end
    end

    assign count_o              = state_q.count;
    assign uncore_issue_block_o = state_q.issue_block;

    // ****************************************************************
    // Checks
    // ****************************************************************
    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (!reset_n_i);

    logic um_sq;
    logic um_any;
    assign um_sq  = sel_is(sel_i, 1'b0, `PESD_EV_SQ_FULL) &&
                    sel_i.unit_mask == `PESD_UM_SQ_FULL;
    assign um_any = sel_is(sel_i, 1'b0, `PESD_EV_FLOAT_ASSIST) &&
                    sel_i.unit_mask == `PESD_UM_ASSIST_ANY;

    sq_count_a : assert property (um_sq && core_ev_i.super_queue_full
        |=> count_o == $past(count_o) + 1'b1)
        else $error("super queue full cycle not counted");
    sq_block_a : assert property (core_ev_i.super_queue_full
        |=> uncore_issue_block_o == 2'b11)
        else $error("uncore issue not blocked while queue full");
    sse_assist_a : assert property (um_any && !core_ev_i.x87_op && core_ev_i.sse_op &&
        core_ev_i.sse_denormal_in && core_ev_i.denormals_as_zero_flag &&
        !core_ev_i.sse_underflow |=> count_o == $past(count_o))
        else $error("assist counted with denormals as zero set");
    x87_assist_a : assert property (um_any && core_ev_i.x87_op &&
        core_ev_i.x87_div_zero |=> count_o == $past(count_o) + 1'b1)
        else $error("x87 divide by zero assist not counted");
    result_assist_a : assert property (sel_is(sel_i, 1'b0, `PESD_EV_FLOAT_ASSIST) &&
        sel_i.unit_mask == `PESD_UM_ASSIST_RES && core_ev_i.x87_op &&
        core_ev_i.x87_underflow |=> count_o == $past(count_o) + 1'b1)
        else $error("bad result assist not counted");
    operand_assist_a : assert property (sel_is(sel_i, 1'b0, `PESD_EV_FLOAT_ASSIST) &&
        sel_i.unit_mask == `PESD_UM_ASSIST_OPND && !core_ev_i.x87_op &&
        !core_ev_i.sse_op |=> count_o == $past(count_o))
        else $error("operand assist counted with no operation");
    vec_multi_a : assert property (sel_is(sel_i, 1'b0, `PESD_EV_VEC64) &&
        sel_i.unit_mask == `PESD_UM_VEC64_ALL
        |=> count_o == $past(count_o) + CNT_W'($countones($past(core_ev_i.vec64_ops))))
        else $error("vector op classes miscounted");
    gq_full_a : assert property (sel_is(sel_i, 1'b1, `PESD_EV_GQ_FULL) &&
        sel_i.unit_mask == `PESD_UM_GQ_WRITE && unc_ev_i.write_tracker_full
        |=> count_o == $past(count_o) + 1'b1)
        else $error("write tracker full cycle not counted");
    gq_occ_a : assert property (sel_is(sel_i, 1'b1, `PESD_EV_GQ_OCCUPIED) &&
        sel_i.unit_mask == `PESD_UM_GQ_READ && !unc_ev_i.read_tracker_occupied
        |=> count_o == $past(count_o))
        else $error("empty read tracker cycle counted");
    unmatched_a : assert property (!match |=> $stable(count_o))
        else $error("counter moved on unmatched selection");
    probe_full_a : assert property (sel_is(sel_i, 1'b1, `PESD_EV_GQ_FULL) &&
        sel_i.unit_mask == `PESD_UM_GQ_PROBE && probe_full
        |=> count_o == $past(count_o) + 1'b1)
        else $error("probe tracker full cycle not counted");
    assist_multi_a : assert property (sel_is(sel_i, 1'b0, `PESD_EV_FLOAT_ASSIST) &&
        sel_i.unit_mask == `PESD_LEGAL_ASSIST && core_ev_i.x87_op &&
        core_ev_i.x87_div_zero && !core_ev_i.x87_underflow
        |=> count_o == $past(count_o) + 2'h2)
        else $error("assist with two selected causes not counted twice");
    block_release_a : assert property (!core_ev_i.super_queue_full
        |=> uncore_issue_block_o == 2'h0)
        else $error("uncore issue still blocked after queue drained");

    sq_count_cv : cover property ((um_sq && core_ev_i.super_queue_full)[*3]);
    vec_multi_cv : cover property (inc > 4'h1);
    probe_count_cv : cover property (sel_is(sel_i, 1'b1, `PESD_EV_GQ_FULL) && probe_full);
    unmatched_cv : cover property (!match && core_ev_i.super_queue_full);

endmodule

// ### verification/tb_pesd_top.sv
// Self-checking bench for the event-selection decoder and its counter.
// Assumes the rtl package and modules compiled first; drives every port.
`timescale 1ns/1ps

module tb_pesd_top;

    // ****************************************************************
    // Settings and signals
    // ****************************************************************
    localparam int CW    = 48;
    localparam int PD    = 4;
    localparam int LIMIT = 1000;
    localparam pesd_pkg::pesd_core_ev_t CZ = '0;
    localparam pesd_pkg::pesd_unc_ev_t  UZ = '0;
    // Assist outcome per case: any, result-caused, operand-caused
    localparam logic [7:0] EXP_ANY  = 8'h75;
    localparam logic [7:0] EXP_RES  = 8'h44;
    localparam logic [7:0] EXP_OPND = 8'h31;

    // Clock and reset
    logic                    clk_i;
    logic                    reset_n_i;
    // Stimulus
    pesd_pkg::pesd_sel_t     sel_i;
    pesd_pkg::pesd_core_ev_t core_ev_i;
    pesd_pkg::pesd_unc_ev_t  unc_ev_i;
    // Results
    logic [CW-1:0]           count_o;
    logic [1:0]              uncore_issue_block_o;
    // Bookkeeping
    int                      n_fail;
    int                      tests_run;
    int                      cycles = 0;

    pesd_top #(.CNT_W(CW), .PROBE_DEPTH(PD)) i_pesd_top (
        .clk_i                (clk_i),
        .reset_n_i            (reset_n_i),
        .sel_i                (sel_i),
        .core_ev_i            (core_ev_i),
        .unc_ev_i             (unc_ev_i),
        .count_o              (count_o),
        .uncore_issue_block_o (uncore_issue_block_o)
    );

    // ****************************************************************
    // Clock, timeout and closing report
    // ****************************************************************
    initial begin
        clk_i = 1'h0;
        forever #5 clk_i = ~clk_i;
    end

    always @(posedge clk_i) begin
        cycles = cycles + 1;
        if (cycles == LIMIT) begin
            n_fail = n_fail + 1;
            $display("[FAIL] %0t run did not finish in time", $time);
            report_and_stop();
        end
    end

    task automatic report_and_stop();
        $display("Mismatches %0d, comparisons %0d", n_fail, tests_run);
        if (n_fail == 0 && tests_run > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask

    // ****************************************************************
    // Compare and drive helpers
    // ****************************************************************
    task automatic chk_cnt(input logic [CW-1:0] exp);
        tests_run = tests_run + 1;
        if (count_o !== exp) begin
            n_fail = n_fail + 1;
            $display("[FAIL] %0t count %0h expected %0h", $time, count_o, exp);
        end
    endtask

    task automatic chk_blk(input logic [1:0] exp);
        tests_run = tests_run + 1;
        if (uncore_issue_block_o !== exp) begin
            n_fail = n_fail + 1;
            $display("[FAIL] %0t issue block %0h expected %0h", $time,
                     uncore_issue_block_o, exp);
        end
    endtask

    // One cycle of strobes, then the count must have grown by inc
    task automatic pulse(input logic u, input logic [7:0] ev, input logic [7:0] um,
                         input pesd_pkg::pesd_core_ev_t c,
                         input pesd_pkg::pesd_unc_ev_t x, input logic [3:0] inc);
        logic [CW-1:0] base;
        base      = count_o;
        sel_i     = '{uncore: u, event_num: ev, unit_mask: um};
        core_ev_i = c;
        unc_ev_i  = x;
        @(posedge clk_i);
        #1;
        chk_cnt(base + CW'(inc));
    endtask

    function automatic pesd_pkg::pesd_core_ev_t assist_case(input int i);
        pesd_pkg::pesd_core_ev_t c;
        c = CZ;
        c.sse_op                 = (i < 4);
        c.sse_denormal_in        = (i == 0) || (i == 1) || (i == 7);
        c.denormals_as_zero_flag = (i == 1);
        c.sse_underflow          = (i == 2) || (i == 3);
        c.flush_to_zero_flag     = (i == 3);
        c.x87_op                 = (i >= 4) && (i <= 6);
        c.x87_nan_denormal_load  = (i == 4);
        c.x87_div_zero           = (i == 5) || (i == 7);
        c.x87_underflow          = (i == 6);
        return c;
    endfunction

    // ****************************************************************
    // Scenarios
    // ****************************************************************
    task automatic t_sq_full();
        pesd_pkg::pesd_core_ev_t c;
        c = CZ;
        c.super_queue_full = 1'h1;
        pulse(1'h0, 8'hF6, 8'h01, c, UZ, 4'h1);
        chk_blk(2'h3);
        pulse(1'h0, 8'hF6, 8'h01, c, UZ, 4'h1);
        chk_blk(2'h3);
        pulse(1'h0, 8'hF6, 8'h01, c, UZ, 4'h1);
        chk_blk(2'h3);
        pulse(1'h0, 8'hF6, 8'h01, CZ, UZ, 4'h0);
        chk_blk(2'h0);
        pulse(1'h0, 8'hFD, 8'h7F, c, UZ, 4'h0);
        chk_blk(2'h3);
    endtask

    task automatic t_assist();
        logic [7:0] masks [4] = '{8'h01, 8'h02, 8'h04, 8'h07};
        logic [3:0] inc;
        pesd_pkg::pesd_core_ev_t c;
        for (int m = 0; m < 4; m++) begin
            for (int i = 0; i < 8; i++) begin
                inc = {3'h0, masks[m][0] & EXP_ANY[i]} + {3'h0, masks[m][1] & EXP_RES[i]}
                    + {3'h0, masks[m][2] & EXP_OPND[i]};
                c   = assist_case(i);
                pulse(1'h0, 8'hF7, masks[m], c, UZ, inc);
            end
        end
    endtask

    task automatic t_vec64();
        pesd_pkg::pesd_core_ev_t c;
        c = CZ;
        for (int b = 0; b < 7; b++) begin
            c.vec64_ops = 7'h7F;
            pulse(1'h0, 8'hFD, 8'h01 << b, c, UZ, 4'h1);
            c.vec64_ops = 7'h7F & ~(7'h01 << b);
            pulse(1'h0, 8'hFD, 8'h01 << b, c, UZ, 4'h0);
        end
        c.vec64_ops = 7'h7F;
        pulse(1'h0, 8'hFD, 8'h7F, c, UZ, 4'h7);
        c.vec64_ops = 7'h15;
        pulse(1'h0, 8'hFD, 8'h7F, c, UZ, 4'h3);
    endtask

    task automatic t_gq();
        pesd_pkg::pesd_unc_ev_t x;
        x = UZ;
        x.read_tracker_full = 1'h1;
        pulse(1'h1, 8'h00, 8'h01, CZ, x, 4'h1);
        pulse(1'h1, 8'h00, 8'h02, CZ, x, 4'h0);
        x.write_tracker_full = 1'h1;
        pulse(1'h1, 8'h00, 8'h02, CZ, x, 4'h1);
        pulse(1'h1, 8'h00, 8'h03, CZ, x, 4'h2);
        x.read_tracker_occupied = 1'h1;
        pulse(1'h1, 8'h01, 8'h01, CZ, x, 4'h1);
        x.read_tracker_occupied = 1'h0;
        pulse(1'h1, 8'h01, 8'h01, CZ, x, 4'h0);
    endtask

    task automatic t_probe();
        pesd_pkg::pesd_unc_ev_t x;
        x = UZ;
        x.probe_alloc_io_hub = 1'h1;
        for (int k = 0; k < PD - 1; k++) begin
            pulse(1'h1, 8'h00, 8'h04, CZ, x, 4'h0);
        end
        x.probe_alloc_remote = 1'h1;
        pulse(1'h1, 8'h00, 8'h04, CZ, x, 4'h0);
        pulse(1'h1, 8'h00, 8'h04, CZ, UZ, 4'h1);
        x = UZ;
        x.probe_dealloc      = 1'h1;
        x.probe_alloc_remote = 1'h1;
        pulse(1'h1, 8'h00, 8'h04, CZ, x, 4'h1);
        pulse(1'h1, 8'h00, 8'h04, CZ, UZ, 4'h1);
        x.probe_alloc_remote = 1'h0;
        for (int k = 0; k < PD; k++) begin
            pulse(1'h1, 8'h00, 8'h04, CZ, x, (k == 0) ? 4'h1 : 4'h0);
        end
    endtask

    task automatic t_unmatched();
        logic [16:0] sels [7] = '{{1'h0, 8'hF6, 8'h03}, {1'h1, 8'hF6, 8'h01},
                                  {1'h0, 8'hFD, 8'h00}, {1'h0, 8'hFD, 8'h80},
                                  {1'h0, 8'hF5, 8'h01}, {1'h1, 8'h01, 8'h02},
                                  {1'h1, 8'h00, 8'h08}};
        for (int i = 0; i < 7; i++) begin
            pulse(sels[i][16], sels[i][15:8], sels[i][7:0], '1, '1, 4'h0);
        end
    endtask

    task automatic t_reset();
        pesd_pkg::pesd_core_ev_t c;
        c = CZ;
        c.super_queue_full = 1'h1;
        pulse(1'h0, 8'hF6, 8'h01, c, UZ, 4'h1);
        reset_n_i = 1'h0;
        core_ev_i = CZ;
        #2;
        chk_cnt('0);
        chk_blk(2'h0);
        @(posedge clk_i);
        #1;
        reset_n_i = 1'h1;
        pulse(1'h0, 8'hF6, 8'h01, CZ, UZ, 4'h0);
    endtask

    // ****************************************************************
    // Main sequence
    // ****************************************************************
    initial begin
        n_fail    = 0;
        tests_run = 0;
        reset_n_i = 1'h0;
        sel_i     = '0;
        core_ev_i = CZ;
        unc_ev_i  = UZ;
        repeat (12) @(posedge clk_i);
        #1;
        reset_n_i = 1'h1;
        chk_cnt('0);
        chk_blk(2'h0);
        t_sq_full();
        t_assist();
        t_vec64();
        t_gq();
        t_probe();
        t_unmatched();
        t_reset();
        report_and_stop();
    end

endmodule
